// *** verilog/lcdr_defines.svh ***
// register offsets, field layouts and reset values of the dimming registers
`ifndef LCDR_DEFINES_SVH
`define LCDR_DEFINES_SVH

`define LCDR_OFS_CH10_DUTY_HIGH    8'h27
`define LCDR_OFS_CH11_CURRENT_CODE 8'h28
`define LCDR_OFS_CH11_DUTY_LOW     8'h29
`define LCDR_OFS_CH11_DUTY_HIGH    8'h2a
`define LCDR_OFS_CH12_CURRENT_CODE 8'h2b
`define LCDR_OFS_CH12_DUTY_LOW     8'h2c
`define LCDR_OFS_CH12_DUTY_HIGH    8'h2d
`define LCDR_OFS_CH13_CURRENT_CODE 8'h2e
`define LCDR_OFS_CH13_DUTY_LOW     8'h2f
`define LCDR_OFS_CH13_DUTY_HIGH    8'h30

`define LCDR_FIRST_CH              2'h1
`define LCDR_CH_COUNT              3
`define LCDR_REG_STRIDE            8'h03
`define LCDR_SLOT_CODE             2'h0
`define LCDR_SLOT_LOW              2'h1
`define LCDR_SLOT_HIGH             2'h2

`define LCDR_CODE_MSB              5
`define LCDR_LOW_MSB               3
`define LCDR_CODE_FULL             6'h3f
`define LCDR_RST_CODE              6'h3f
`define LCDR_RST_LOW               4'hf
`define LCDR_RST_HIGH              8'hff
`define LCDR_RST_DUTY              12'hfff
`define LCDR_RDATA_IDLE            8'h00

`endif

// *** verilog/lcdr_pkg.sv ***
// types shared by the dimming register block
`default_nettype none
package lcdr_pkg;
	typedef logic [7:0]  lcdr_byte_t;
	typedef logic [5:0]  lcdr_code_t;
	typedef logic [3:0]  lcdr_nib_t;
	typedef logic [11:0] lcdr_duty_t;
	typedef enum logic [1:0]
	{
		LCDR_ACC_IDLE,
		LCDR_ACC_WRITE,
		LCDR_ACC_READ
	} lcdr_acc_e;
endpackage
`default_nettype wire

// *** verilog/lcdr_chan_if.sv ***
// per-channel write strobes carried from the decoder to the channel stores
`timescale 1ns/1ps
`default_nettype none
interface lcdr_chan_if;
	import lcdr_pkg::*;
	logic       wr_code;
	logic       wr_low;
	logic       wr_high;
	lcdr_byte_t wdata;
	modport dec (output wr_code, output wr_low, output wr_high, output wdata);
	modport chan (input wr_code, input wr_low, input wr_high, input wdata);
endinterface
`default_nettype wire

// *** verilog/lcdr_chan.sv ***
// one channel store: current code, pending low nibble, applied duty
`timescale 1ns/1ps
`default_nettype none
`include "lcdr_defines.svh"
module lcdr_chan
	import lcdr_pkg::*;
(
	input  wire logic  i_clock,
	input  wire logic  i_srst,
	lcdr_chan_if.chan  bus,
	output logic [5:0] o_code,
	output logic [3:0] o_low,
	output logic [7:0] o_high,
	output logic [11:0] o_duty
);
	lcdr_code_t code_ff;
	lcdr_code_t nxt_code;
	lcdr_nib_t  low_ff;
	lcdr_nib_t  nxt_low;
	lcdr_byte_t high_ff;
	lcdr_byte_t nxt_high;
	lcdr_duty_t duty_ff;
	lcdr_duty_t nxt_duty;

	always_comb
	begin
		nxt_code = code_ff;
		nxt_low  = low_ff;
		nxt_high = high_ff;
		nxt_duty = duty_ff;
		if (bus.wr_code)
			nxt_code = bus.wdata[`LCDR_CODE_MSB:0];
		if (bus.wr_low)
			nxt_low = bus.wdata[`LCDR_LOW_MSB:0];
		if (bus.wr_high)
		begin
			nxt_high = bus.wdata;
			// pending nibble joins the new high byte in the same edge
			nxt_duty = {bus.wdata, low_ff};
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			code_ff <= `LCDR_RST_CODE;
			low_ff  <= `LCDR_RST_LOW;
			high_ff <= `LCDR_RST_HIGH;
			duty_ff <= `LCDR_RST_DUTY;
		end
		else
		begin
			code_ff <= nxt_code;
			low_ff  <= nxt_low;
			high_ff <= nxt_high;
			duty_ff <= nxt_duty;
		end
	end

	assign o_code = code_ff;
	assign o_low  = low_ff;
	assign o_high = high_ff;
	assign o_duty = duty_ff;
endmodule
`default_nettype wire

// *** verilog/lcdr_ch10_high.sv ***
// channel 10 high duty byte: only its upper part lives in this block
`timescale 1ns/1ps
`default_nettype none
`include "lcdr_defines.svh"
module lcdr_ch10_high
	import lcdr_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_srst,
	input  wire logic       i_wr,
	input  wire logic [7:0] i_wdata,
	input  wire logic [3:0] i_low,
	output logic [7:0]      o_high,
	output logic            o_apply,
	output logic [11:0]     o_duty
);
	lcdr_byte_t high_ff;
	lcdr_byte_t nxt_high;
	logic       apply_ff;
	logic       nxt_apply;
	lcdr_duty_t duty_ff;
	lcdr_duty_t nxt_duty;

	always_comb
	begin
		nxt_high  = high_ff;
		nxt_duty  = duty_ff;
		nxt_apply = 1'b0;
		if (i_wr)
		begin
			nxt_high  = i_wdata;
			nxt_duty  = {i_wdata, i_low};
			nxt_apply = 1'b1;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			high_ff  <= `LCDR_RST_HIGH;
			duty_ff  <= `LCDR_RST_DUTY;
			apply_ff <= 1'b0;
		end
		else
		begin
			high_ff  <= nxt_high;
			duty_ff  <= nxt_duty;
			apply_ff <= nxt_apply;
		end
	end

	assign o_high  = high_ff;
	assign o_apply = apply_ff;
	assign o_duty  = duty_ff;
endmodule
`default_nettype wire

// *** verilog/lcdr_top.sv ***
// dimming setting registers for LED channels 10 (high byte) to 13
`timescale 1ns/1ps
`default_nettype none
`include "lcdr_defines.svh"

// Overview of operation
// - six-bit current code, current scales code over 63
// - duty is low nibble plus high byte
// - duty applies only on high byte write
// - three consecutive addresses per channel for 11 to 13, code first; channel 10 has its high byte only
// - reset to all ones, reserved bits read zero
module lcdr_top
	import lcdr_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_srst,
	input  wire logic        i_wr_en,
	input  wire logic        i_rd_en,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic [3:0]  i_ch10_low,
	output logic [7:0]       o_rdata,
	output logic             o_rvalid,
	output logic [11:0]      o_ch10_duty_field,
	output logic [5:0]       o_ch11_current_code_field,
	output logic [11:0]      o_ch11_duty_field,
	output logic [5:0]       o_ch12_current_code_field,
	output logic [11:0]      o_ch12_duty_field,
	output logic [5:0]       o_ch13_current_code_field,
	output logic [11:0]      o_ch13_duty_field,
	output logic [3:0]       o_duty_apply
);
	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	// maps an address to its channel index (0..2 for ch11..13) and slot
	function automatic logic [3:0] lcdr_decode(input logic [7:0] addr);
		logic [7:0] rel;
		logic [1:0] ch;
		logic [1:0] slot;
		logic       hit;
		rel  = addr - `LCDR_OFS_CH11_CURRENT_CODE;
		hit  = (addr >= `LCDR_OFS_CH11_CURRENT_CODE) && (addr <= `LCDR_OFS_CH13_DUTY_HIGH);
		ch   = 2'(rel / `LCDR_REG_STRIDE);
		slot = 2'(rel % `LCDR_REG_STRIDE);
		return hit ? {ch, slot} : 4'hf;
	endfunction

	logic [3:0] dec;
	logic       hit_ch10;
	assign dec      = lcdr_decode(i_addr);
	assign hit_ch10 = (i_addr == `LCDR_OFS_CH10_DUTY_HIGH);

	lcdr_chan_if cif [`LCDR_CH_COUNT] ();

	logic [5:0]  code_q [`LCDR_CH_COUNT];
	logic [3:0]  low_q  [`LCDR_CH_COUNT];
	logic [7:0]  high_q [`LCDR_CH_COUNT];
	logic [11:0] duty_q [`LCDR_CH_COUNT];
	logic [`LCDR_CH_COUNT-1:0] apply_q;
	logic [7:0]  ch10_high;
	logic        ch10_apply;

	// ---------------------------------------------------------------
	// channel stores
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `LCDR_CH_COUNT; g++)
		begin : g_ch
			// single-byte writes: one strobe per accepted transfer
			assign cif[g].wr_code = i_wr_en && (dec == {2'(g), `LCDR_SLOT_CODE});
			assign cif[g].wr_low  = i_wr_en && (dec == {2'(g), `LCDR_SLOT_LOW});
			assign cif[g].wr_high = i_wr_en && (dec == {2'(g), `LCDR_SLOT_HIGH});
			assign cif[g].wdata   = i_wdata;

			lcdr_chan u_chan
			(
				.i_clock (i_clock),
				.i_srst  (i_srst),
				.bus     (cif[g]),
				.o_code  (code_q[g]),
				.o_low   (low_q[g]),
				.o_high  (high_q[g]),
				.o_duty  (duty_q[g])
			);
		end
	endgenerate

	// low nibble of channel 10 is held outside; it is merged on the high write
	lcdr_ch10_high u_ch10
	(
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.i_wr    (i_wr_en && hit_ch10),
		.i_wdata (i_wdata),
		.i_low   (i_ch10_low),
		.o_high  (ch10_high),
		.o_apply (ch10_apply),
		.o_duty  (o_ch10_duty_field)
	);

	// ---------------------------------------------------------------
	// apply pulses
	// ---------------------------------------------------------------
	logic [`LCDR_CH_COUNT-1:0] apply_ff;
	logic [`LCDR_CH_COUNT-1:0] nxt_apply;

	always_comb
	begin
		for (int k = 0; k < `LCDR_CH_COUNT; k++)
			nxt_apply[k] = cif[0].wr_high && (k == 0) ||
			               cif[1].wr_high && (k == 1) ||
			               cif[2].wr_high && (k == 2);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			apply_ff <= '0;
		else
			apply_ff <= nxt_apply;
	end

	assign apply_q      = apply_ff;
	assign o_duty_apply = {apply_q, ch10_apply};

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	lcdr_byte_t rdata_ff;
	lcdr_byte_t nxt_rdata;
	logic       rvalid_ff;
	logic       nxt_rvalid;

	always_comb
	begin
		nxt_rdata  = `LCDR_RDATA_IDLE;
		nxt_rvalid = i_rd_en;
		if (i_rd_en)
		begin
			if (hit_ch10)
				nxt_rdata = ch10_high;
			else if (dec != 4'hf)
			begin
				case (dec[1:0])
					`LCDR_SLOT_CODE: nxt_rdata = {2'b00, code_q[dec[3:2]]};
					`LCDR_SLOT_LOW:  nxt_rdata = {4'h0, low_q[dec[3:2]]};
					`LCDR_SLOT_HIGH: nxt_rdata = high_q[dec[3:2]];
					default:         nxt_rdata = `LCDR_RDATA_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			rdata_ff  <= `LCDR_RDATA_IDLE;
			rvalid_ff <= 1'b0;
		end
		else
		begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	assign o_rdata  = rdata_ff;
	assign o_rvalid = rvalid_ff;

	// current = code / 63 * full-scale; the analog stage does the scaling
	assign o_ch11_current_code_field = code_q[0];
	assign o_ch12_current_code_field = code_q[1];
	assign o_ch13_current_code_field = code_q[2];
	assign o_ch11_duty_field         = duty_q[0];
	assign o_ch12_duty_field         = duty_q[1];
	assign o_ch13_duty_field         = duty_q[2];
endmodule
`default_nettype wire

// *** sim/lcdr_monitor.sv ***
// port assertions for the dimming register block
`timescale 1ns/1ps
`default_nettype none
module lcdr_monitor
(
	input wire logic        i_clock,
	input wire logic        i_srst,
	input wire logic        i_wr_en,
	input wire logic        i_rd_en,
	input wire logic [7:0]  i_addr,
	input wire logic [7:0]  i_wdata,
	input wire logic [3:0]  i_ch10_low,
	input wire logic [7:0]  o_rdata,
	input wire logic        o_rvalid,
	input wire logic [11:0] o_ch10_duty_field,
	input wire logic [11:0] o_ch11_duty_field,
	input wire logic [5:0]  o_ch12_current_code_field,
	input wire logic [5:0]  o_ch13_current_code_field,
	input wire logic [11:0] o_ch13_duty_field,
	input wire logic [3:0]  o_duty_apply
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);
	property p_rvalid; i_rd_en |=> o_rvalid; endproperty
	a_rvalid: assert property (p_rvalid) else $error("no valid after read");
	property p_idle; !i_rd_en |=> o_rdata == 8'h00 && !o_rvalid; endproperty
	a_idle: assert property (p_idle) else $error("read bus not idle");
	property p_unmap; i_rd_en && !i_wr_en && (i_addr < 8'h27 || i_addr > 8'h30) |=> o_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_code_rd; i_rd_en && !i_wr_en && i_addr == 8'h2e |=> o_rdata == {2'b00, o_ch13_current_code_field}; endproperty
	a_code_rd: assert property (p_code_rd) else $error("code readback wrong");
	property p_low_hold; i_wr_en && i_addr == 8'h29 |=> $stable(o_ch11_duty_field) && !o_duty_apply[1]; endproperty
	a_low_hold: assert property (p_low_hold) else $error("low write moved duty");
	property p_apply; i_wr_en && i_addr == 8'h2a |=> o_duty_apply == 4'h2 && o_ch11_duty_field[11:4] == $past(i_wdata); endproperty
	a_apply: assert property (p_apply) else $error("high write not applied");
	property p_ch10; i_wr_en && i_addr == 8'h27 |=> o_ch10_duty_field == {$past(i_wdata), $past(i_ch10_low)}; endproperty
	a_ch10: assert property (p_ch10) else $error("channel 10 duty wrong");
	property p_no_apply; !i_wr_en |=> o_duty_apply == 4'h0; endproperty
	a_no_apply: assert property (p_no_apply) else $error("apply without write");
	property p_code_wr; i_wr_en && i_addr == 8'h2b |=> {2'b00, o_ch12_current_code_field} == ($past(i_wdata) & 8'h3f); endproperty
	a_code_wr: assert property (p_code_wr) else $error("code write wrong");
	property p_rst; $fell(i_srst) |-> o_ch13_duty_field == 12'hfff && o_ch13_current_code_field == 6'h3f; endproperty
	a_rst: assert property (p_rst) else $error("reset value wrong");
	c_apply: cover property (o_duty_apply[1]);
	c_unmap: cover property (i_rd_en && i_addr == 8'h31);
	c_reset: cover property ($fell(i_srst));
endmodule
`default_nettype wire

// *** sim/lcdr_host_model.sv ***
// host side model: single-byte register writes and reads
`timescale 1ns/1ps
`default_nettype none
module lcdr_host_model
(
	input  wire logic  i_clock,
	output logic       o_wr_en,
	output logic       o_rd_en,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	initial
	begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr  = 8'h00;
		o_wdata = 8'h00;
	end
	// one byte per strobe; the bench writes addresses in random order, a high byte may come without its low nibble
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		o_wr_en <= wr;
		o_rd_en <= !wr;
		o_addr  <= a;
		o_wdata <= d;
		@(posedge i_clock);
		o_wr_en <= 1'b0;
		o_rd_en <= 1'b0;
		// released lines show the inverse so a stale value cannot pass
		o_addr  <= ~a;
		o_wdata <= ~d;
	endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the dimming register block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import lcdr_pkg::*;
	logic        i_clock;
	logic        i_srst;
	logic [3:0]  i_ch10_low;
	wire logic   i_wr_en;
	wire logic   i_rd_en;
	wire logic [7:0] i_addr;
	wire logic [7:0] i_wdata;
	logic [7:0]  o_rdata;
	logic        o_rvalid;
	logic [11:0] o_ch10_duty_field, o_ch11_duty_field, o_ch12_duty_field, o_ch13_duty_field;
	logic [5:0]  o_ch11_current_code_field, o_ch12_current_code_field, o_ch13_current_code_field;
	logic [3:0]  o_duty_apply;
	lcdr_byte_t  mirror [38:49];
	lcdr_duty_t  exp_duty [4];
	logic [3:0]  exp_apply;
	lcdr_byte_t  rq [$];
	int          n_mismatch, comparisons, seed;
	logic [7:0]  a, d;
	lcdr_top i_lcdr_top (.i_clock, .i_srst, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .i_ch10_low, .o_rdata,
		.o_rvalid, .o_ch10_duty_field, .o_ch11_current_code_field, .o_ch11_duty_field, .o_ch12_current_code_field,
		.o_ch12_duty_field, .o_ch13_current_code_field, .o_ch13_duty_field, .o_duty_apply);
	lcdr_host_model i_lcdr_host_model (.i_clock, .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr),
		.o_wdata(i_wdata));
	initial
	begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end
	// ----------------------------------------
	// expectations and comparisons
	// ----------------------------------------
	function automatic lcdr_byte_t mask(logic [7:0] x);
		if (x < 8'h27 || x > 8'h30)
			return 8'h00;
		return ((x - 8'h25) % 3 == 0) ? 8'h3f : ((x - 8'h25) % 3 == 1) ? 8'h0f : 8'hff;
	endfunction
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_read(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t read got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("n_mismatch %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic rst;
		i_srst <= 1'b1;
		repeat (5) @(posedge i_clock);
		i_srst <= 1'b0;
		for (int k = 38; k <= 49; k++) mirror[k] = mask(8'(k));
		for (int k = 0; k < 4; k++) exp_duty[k] = 12'hfff;
		exp_apply = 4'h0;
	endtask
	task automatic rd_reg(input logic [7:0] x);
		rq.push_back(mirror[x]);
		i_lcdr_host_model.access(1'b0, x, 8'h00);
	endtask
	task automatic chk_outputs;
		@(negedge i_clock);
		chk(o_ch10_duty_field, exp_duty[0]);
		chk(o_ch11_duty_field, exp_duty[1]);
		chk(o_ch12_duty_field, exp_duty[2]);
		chk(o_ch13_duty_field, exp_duty[3]);
		chk(12'(o_ch11_current_code_field), 12'(mirror[40]));
		chk(12'(o_ch12_current_code_field), 12'(mirror[43]));
		chk(12'(o_ch13_current_code_field), 12'(mirror[46]));
		chk(12'(o_duty_apply), 12'(exp_apply));
	endtask
	always @(posedge i_clock)
		if (o_rvalid === 1'b1)
			if (rq.size() == 0)
			begin
				n_mismatch++;
				$display("ERROR %0t unexpected read data", $time);
			end
			else
				chk_read(o_rdata, rq.pop_front());
	initial
	begin
		#100us;
		n_mismatch++;
		$display("ERROR %0t watchdog ran out", $time);
		end_sim();
	end
	initial
	begin
		seed = 32'hcd71_d8f0;
		i_srst = 1'b1;
		i_ch10_low = 4'h0;
		for (int pass = 0; pass < 2; pass++)
		begin
			rst();
			for (int k = 38; k <= 49; k++) rd_reg(8'(k));
			chk_outputs();
			for (int n = 0; n < 80; n++)
			begin
				a = 8'h26 + 8'($unsigned($random(seed)) % 12);
				d = 8'($random(seed));
				@(posedge i_clock);
				i_ch10_low <= 4'($random(seed));
				i_lcdr_host_model.access(1'b1, a, d);
				mirror[a] = d & mask(a);
				exp_apply = 4'h0;
				if (mask(a) == 8'hff)
				begin
					exp_duty[a == 8'h27 ? 0 : (a - 8'h27) / 3] = {d, a == 8'h27 ? i_ch10_low : mirror[a - 1][3:0]};
					exp_apply[a == 8'h27 ? 0 : (a - 8'h27) / 3] = 1'b1;
				end
				chk_outputs();
				rd_reg(8'h26 + 8'($unsigned($random(seed)) % 12));
			end
		end
		for (int w = 0; w < 8 && rq.size() != 0; w++) @(posedge i_clock);
		if (rq.size() != 0)
		begin
			n_mismatch++;
			$display("ERROR %0t reads left unanswered", $time);
		end
		end_sim();
	end
endmodule
bind lcdr_top lcdr_monitor i_lcdr_monitor (.i_clock, .i_srst, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .i_ch10_low,
	.o_rdata, .o_rvalid, .o_ch10_duty_field, .o_ch11_duty_field, .o_ch12_current_code_field,
	.o_ch13_current_code_field, .o_ch13_duty_field, .o_duty_apply);
`default_nettype wire
